// ### src/nrps_host.sv
// host sequencer driving a flash device's command, address and data pins
`timescale 1ns/10ps
module nrps_host (
	input logic clock,
	input logic rst_n,
	input nrps_pkg::nrps_order_t order,
	input logic order_valid,
	output logic order_ready,
	output logic order_done,
	output logic order_refused,
	input logic [7:0] wr_data,
	input logic wr_valid,
	output logic wr_ready,
	output logic [7:0] rd_data,
	output logic rd_valid,
	input logic rd_ready,
	output nrps_pkg::nrps_status_t status,
	input logic protect,
	output logic chip_enable_n,
	output logic cmd_latch,
	output logic addr_latch,
	output logic write_strobe_n,
	output logic read_strobe_n,
	output logic write_protect_n,
	output logic [7:0] byte_port_o,
	output logic byte_port_oe,
	input logic [7:0] byte_port_i,
	input logic ready_busy_n
);
	import nrps_pkg::*;

	nrps_state_t state_ff, nxt_state; // sequence position
	logic [1:0] phase_ff; // 0 wait, 1 strobe low, 2 strobe high hold
	logic [CNT_W-1:0] idx_ff; // byte index within the step
	logic [1:0] wb_ff; // settle count before sampling busy
	nrps_order_t ord_ff; // latched order
	nrps_plan_t plan_ff; // latched pin sequence
	logic have_ff; // write byte captured and on the port
	logic wr_ready_ff, order_ready_ff, done_ff, refused_ff;
	logic ce_n_ff, cle_ff, ale_ff, we_n_ff, re_n_ff, wp_n_ff, oe_ff;
	logic [7:0] out_ff; // byte driven on the port
	logic push_ff; // read byte into buffer
	logic [7:0] push_data_ff; // sampled read byte
	nrps_status_t status_ff; // last decoded status byte
	logic [ROW_W-1:0] mread_row_ff; // district last chosen by a multi read select or go
	logic [ROW_W-1:0] cache_row_ff; // page whose data sits in the cache
	logic mprog_open_ff; // between 11h and the next 81h
	logic tick, buf_in_ready, take, accept, refuse, go_fall, go_rise, go_next, last;
	nrps_plan_t new_plan; // pin sequence of the offered order

	nrps_tick #(.DIV(STROBE_DIV)) u_tick (
		.clock(clock),
		.rst_n(rst_n),
		.tick(tick)
	);

	nrps_buf2 #(.W(8)) u_buf (
		.clock(clock),
		.rst_n(rst_n),
		.in_valid(push_ff),
		.in_data(push_data_ff),
		.in_ready(buf_in_ready),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data(rd_data)
	);

	// address byte by position: column low, column high, three row bytes
	function automatic logic [7:0] addr_byte(input logic [COL_W-1:0] col,
		input logic [ROW_W-1:0] row, input logic [2:0] i);
		case (i)
			3'h0: addr_byte = col[7:0];
			3'h1: addr_byte = {3'h0, col[12:8]};
			3'h2: addr_byte = row[7:0];
			3'h3: addr_byte = row[15:8];
			3'h4: addr_byte = {7'h00, row[16]}; // unused bits low
			default: addr_byte = BYTE_RST;
		endcase
	endfunction : addr_byte

	// pin sequence for an order
	function automatic nrps_plan_t make_plan(input nrps_order_t o);
		nrps_plan_t p;
		p = '0;
		p.has_cmd1 = 1'b1;
		case (o.op)
			OP_READ, OP_READ_NOCMD:
			begin
				p.has_cmd1 = (o.op == OP_READ); // power-up default is 00h
				p.cmd1 = CMD_READ;
				p.naddr = ADDR_FULL;
				p.has_cmd2 = 1'b1;
				p.cmd2 = CMD_READ_GO;
				p.wait_rb = 1'b1;
				p.rd = 1'b1;
			end
			OP_COL_READ:
			begin
				p.cmd1 = CMD_COL_OUT;
				p.naddr = ADDR_COL;
				p.has_cmd2 = 1'b1;
				p.cmd2 = CMD_COL_OUT_GO;
				p.rd = 1'b1;
			end
			OP_CACHE_NEXT, OP_CACHE_LAST:
			begin
				// 3Fh starts no array load, 31h does; both wait busy
				p.cmd1 = (o.op == OP_CACHE_NEXT) ? CMD_CACHE_NEXT : CMD_CACHE_LAST;
				p.wait_rb = 1'b1;
				p.rd = 1'b1;
			end
			OP_MREAD_SEL, OP_MREAD_GO:
			begin
				p.cmd1 = CMD_MREAD_SEL;
				p.naddr = ADDR_ROW;
				p.addr_first = ADDR_ROW_FIRST;
				p.has_cmd2 = (o.op == OP_MREAD_GO);
				p.cmd2 = CMD_READ_GO;
				p.wait_rb = (o.op == OP_MREAD_GO);
				p.rd = (o.op == OP_MREAD_GO);
			end
			OP_PROG, OP_PROG_MD, OP_PROG_COL:
			begin
				p.cmd1 = (o.op == OP_PROG) ? CMD_PROG :
					(o.op == OP_PROG_MD) ? CMD_PROG_MD : CMD_COL_IN;
				p.naddr = (o.op == OP_PROG_COL) ? ADDR_COL : ADDR_FULL;
				p.wr = 1'b1;
				p.has_cmd2 = (o.close != CL_NONE);
				p.cmd2 = (o.close == CL_GO) ? CMD_PROG_GO :
					(o.close == CL_HOLD) ? CMD_PROG_MD_HOLD : CMD_PROG_CACHE;
				p.wait_rb = (o.close != CL_NONE);
			end
			OP_STATUS:
			begin
				p.cmd1 = CMD_STATUS;
				p.rd = 1'b1;
			end
			OP_RESET:
			begin
				p.cmd1 = CMD_RESET;
				p.wait_rb = 1'b1;
			end
			default:
			begin
				p.has_cmd1 = 1'b0;
			end
		endcase
		p.wr = p.wr && (o.count != CNT_RST);
		p.rd = p.rd && ((o.op == OP_STATUS) || (o.count != CNT_RST));
		make_plan = p;
	endfunction : make_plan

	// routing: step that follows each step when later ones are skipped
	function automatic nrps_state_t after_cmd2(input nrps_plan_t p);
		after_cmd2 = p.wait_rb ? ST_WB : (p.rd ? ST_DATA : ST_IDLE);
	endfunction : after_cmd2

	function automatic nrps_state_t after_wdata(input nrps_plan_t p);
		after_wdata = p.has_cmd2 ? ST_CMD2 : after_cmd2(p);
	endfunction : after_wdata

	function automatic nrps_state_t after_addr(input nrps_plan_t p);
		after_addr = p.wr ? ST_DATA : after_wdata(p);
	endfunction : after_addr

	function automatic nrps_state_t after_cmd1(input nrps_plan_t p);
		after_cmd1 = (p.naddr != 3'h0) ? ST_ADDR : after_addr(p);
	endfunction : after_cmd1

	// order screening for the far side's addressing and command rules
	always_comb
	begin
		refuse = 1'b0;
		if (mprog_open_ff && !(order.op inside {OP_PROG_MD, OP_STATUS, OP_RESET}))
		begin
			refuse = 1'b1;
		end
		else if (order.op == OP_MREAD_GO)
		begin
			// same page bits, other district
			refuse = (order.row[PAGE_BITS-1:0] != mread_row_ff[PAGE_BITS-1:0]) ||
				(order.row[DISTRICT_BIT] == mread_row_ff[DISTRICT_BIT]);
		end
		else if (order.op == OP_CACHE_NEXT)
		begin
			refuse = (cache_row_ff[PAGE_BITS-1:0] == PAGE_LAST); // block would change
		end
	end

	assign take = order_valid && order_ready_ff;
	assign accept = take && !refuse;
	assign new_plan = make_plan(order);
	// strobes only in byte steps: one while idle or waiting would land as a data byte
	assign go_fall = tick && (phase_ff == 2'h0) && ((state_ff inside {ST_CMD1, ST_ADDR, ST_CMD2}) ||
		((state_ff == ST_DATA) && (plan_ff.wr ? have_ff : buf_in_ready)));
	assign go_rise = tick && (phase_ff == 2'h1);
	assign go_next = tick && (phase_ff == 2'h2);
	assign last = (state_ff == ST_ADDR) ? (idx_ff == CNT_W'(plan_ff.naddr - 3'h1)) :
		(state_ff == ST_DATA) ? (idx_ff == ord_ff.count - CNT_W'(1)) : 1'b1;

	// next step of the sequence
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: if (accept) nxt_state = new_plan.has_cmd1 ? ST_CMD1 : after_cmd1(new_plan);
			ST_CMD1: if (go_next) nxt_state = after_cmd1(plan_ff);
			ST_ADDR: if (go_next && last) nxt_state = after_addr(plan_ff);
			ST_DATA: if (go_next && last) nxt_state = plan_ff.wr ? after_wdata(plan_ff) :
				ST_IDLE;
			ST_CMD2: if (go_next) nxt_state = after_cmd2(plan_ff);
			ST_WB: if (wb_ff == 2'h0) nxt_state = ST_BUSY;
			ST_BUSY: if (ready_busy_n) nxt_state = plan_ff.rd ? ST_DATA : ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	// sequence position, strobe phase and byte index
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			state_ff <= ST_IDLE;
			phase_ff <= 2'h0;
			idx_ff <= CNT_RST;
			wb_ff <= 2'h0;
		end
		else
		begin
			state_ff <= nxt_state;
			if (nxt_state != state_ff)
			begin
				phase_ff <= 2'h0;
				idx_ff <= CNT_RST;
				wb_ff <= WB_LOAD;
			end
			else if (go_fall || go_rise)
			begin
				phase_ff <= phase_ff + 2'h1;
			end
			else if (go_next)
			begin
				phase_ff <= 2'h0;
				idx_ff <= idx_ff + CNT_W'(1); // one byte per strobe
			end
			else if (state_ff == ST_WB)
			begin
				wb_ff <= wb_ff - 2'h1; // settle before trusting ready/busy
			end
		end
	end

	// order handshake and tracking of multi-step context
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			ord_ff <= '0;
			plan_ff <= '0;
			order_ready_ff <= 1'b0;
			done_ff <= 1'b0;
			refused_ff <= 1'b0;
			mread_row_ff <= ROW_RST;
			cache_row_ff <= ROW_RST;
			mprog_open_ff <= 1'b0;
		end
		else
		begin
			order_ready_ff <= (nxt_state == ST_IDLE) && !take;
			done_ff <= (state_ff != ST_IDLE) && (nxt_state == ST_IDLE);
			refused_ff <= take && refuse;
			if (accept)
			begin
				ord_ff <= order;
				if (order.op == OP_STATUS)
				begin
					ord_ff.count <= CNT_W'(1);
				end
				plan_ff <= new_plan;
				if (order.op inside {OP_MREAD_SEL, OP_MREAD_GO})
				begin
					mread_row_ff <= order.row;
				end
				if (order.op inside {OP_READ, OP_READ_NOCMD, OP_MREAD_GO})
				begin
					cache_row_ff <= order.row;
				end
				else if (order.op == OP_CACHE_NEXT)
				begin
					cache_row_ff <= cache_row_ff + ROW_W'(1); // next sequential page
				end
				if (order.op inside {OP_PROG_MD, OP_RESET})
				begin
					mprog_open_ff <= 1'b0;
				end
				else if (order.op == OP_PROG && order.close == CL_HOLD)
				begin
					mprog_open_ff <= 1'b1;
				end
			end
		end
	end

	// pins and write byte capture
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			ce_n_ff <= 1'b1;
			cle_ff <= 1'b0;
			ale_ff <= 1'b0;
			we_n_ff <= 1'b1;
			re_n_ff <= 1'b1;
			wp_n_ff <= 1'b0;
			oe_ff <= 1'b0;
			out_ff <= BYTE_RST;
			have_ff <= 1'b0;
			wr_ready_ff <= 1'b0;
		end
		else
		begin
			ce_n_ff <= (nxt_state == ST_IDLE);
			cle_ff <= (nxt_state == ST_CMD1) || (nxt_state == ST_CMD2);
			ale_ff <= (nxt_state == ST_ADDR);
			oe_ff <= (nxt_state inside {ST_CMD1, ST_ADDR, ST_CMD2}) ||
				((nxt_state == ST_DATA) && plan_ff.wr);
			// protect drops only while idle, so it never cuts an operation
			wp_n_ff <= !protect || (nxt_state != ST_IDLE);
			wr_ready_ff <= (state_ff == ST_DATA) && plan_ff.wr && !have_ff &&
				!(wr_valid && wr_ready_ff) && (nxt_state == ST_DATA);
			if (go_fall && (state_ff == ST_DATA) && plan_ff.rd)
			begin
				re_n_ff <= 1'b0;
			end
			else if (go_fall)
			begin
				we_n_ff <= 1'b0;
			end
			if (go_rise)
			begin
				we_n_ff <= 1'b1;
				re_n_ff <= 1'b1;
			end
			if (go_fall && state_ff == ST_CMD1)
			begin
				out_ff <= plan_ff.cmd1;
			end
			else if (go_fall && state_ff == ST_CMD2)
			begin
				out_ff <= plan_ff.cmd2;
			end
			else if (go_fall && state_ff == ST_ADDR)
			begin
				out_ff <= addr_byte(ord_ff.col, ord_ff.row, plan_ff.addr_first + idx_ff[2:0]);
			end
			else if (wr_valid && wr_ready_ff)
			begin
				out_ff <= wr_data;
			end
			if (wr_valid && wr_ready_ff)
			begin
				have_ff <= 1'b1;
			end
			else if (go_next || state_ff != ST_DATA)
			begin
				have_ff <= 1'b0;
			end
		end
	end

	// read capture into the buffer and status decode
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			push_ff <= 1'b0;
			push_data_ff <= BYTE_RST;
			status_ff <= '0;
		end
		else
		begin
			push_ff <= go_rise && (state_ff == ST_DATA) && plan_ff.rd;
			if (go_rise && state_ff == ST_DATA && plan_ff.rd)
			begin
				push_data_ff <= byte_port_i;
				if (ord_ff.op == OP_STATUS)
				begin
					// results only count once their ready bit says so
					status_ff.pb_ready <= byte_port_i[ST_PB_READY];
					status_ff.dc_ready <= byte_port_i[ST_DC_READY];
					status_ff.fail_cur <= byte_port_i[ST_FAIL_CUR] && byte_port_i[ST_PB_READY];
					status_ff.fail_prev <= byte_port_i[ST_FAIL_PREV] && byte_port_i[ST_DC_READY];
				end
			end
		end
	end

	assign order_ready = order_ready_ff;
	assign order_done = done_ff;
	assign order_refused = refused_ff;
	assign wr_ready = wr_ready_ff;
	assign status = status_ff;
	assign chip_enable_n = ce_n_ff;
	assign cmd_latch = cle_ff;
	assign addr_latch = ale_ff;
	assign write_strobe_n = we_n_ff;
	assign read_strobe_n = re_n_ff;
	assign write_protect_n = wp_n_ff;
	assign byte_port_o = out_ff;
	assign byte_port_oe = oe_ff;
endmodule : nrps_host

// ### src/nrps_pkg.sv
// constants, types and order layout for the flash read/program sequencer
// Summary of operation
// - read is 00h, five address bytes, 30h
// - 05h, two column bytes, E0h move output column
// - multi read: same page bits both districts
// - multi read: one block per district
// - cached read restarts when block changes
// - write protect held high during each order, not between multi read orders
// - only 70h or FFh between 11h and 81h
// - cached program ends with 10h, wait ready
// - address is two column then three row bytes
package nrps_pkg;
	// command bytes
	localparam logic [7:0] CMD_READ = 8'h00;
	localparam logic [7:0] CMD_READ_GO = 8'h30;
	localparam logic [7:0] CMD_COL_OUT = 8'h05;
	localparam logic [7:0] CMD_COL_OUT_GO = 8'he0;
	localparam logic [7:0] CMD_CACHE_NEXT = 8'h31;
	localparam logic [7:0] CMD_CACHE_LAST = 8'h3f;
	localparam logic [7:0] CMD_MREAD_SEL = 8'h60;
	localparam logic [7:0] CMD_PROG = 8'h80;
	localparam logic [7:0] CMD_PROG_MD = 8'h81;
	localparam logic [7:0] CMD_COL_IN = 8'h85;
	localparam logic [7:0] CMD_PROG_GO = 8'h10;
	localparam logic [7:0] CMD_PROG_MD_HOLD = 8'h11;
	localparam logic [7:0] CMD_PROG_CACHE = 8'h15;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_RESET = 8'hff;
	// address layout: byte count and first row byte index
	localparam logic [2:0] ADDR_FULL = 3'h5;
	localparam logic [2:0] ADDR_COL = 3'h2;
	localparam logic [2:0] ADDR_ROW = 3'h3;
	localparam logic [2:0] ADDR_ROW_FIRST = 3'h2;
	localparam int COL_W = 13;
	localparam int ROW_W = 17;
	localparam int CNT_W = 13;
	localparam int PAGE_BITS = 6;
	localparam int DISTRICT_BIT = 6;
	localparam logic [5:0] PAGE_LAST = 6'h3f;
	// status byte bit positions
	localparam int ST_FAIL_CUR = 0;
	localparam int ST_FAIL_PREV = 1;
	localparam int ST_PB_READY = 5;
	localparam int ST_DC_READY = 6;
	// timing: clock, write-to-busy settle, strobe phase length
	localparam int CLK_PERIOD_NS = 100;
	localparam int WB_TIME_NS = 100;
	localparam int WB_CYCLES_RAW = (WB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WB_CYCLES = (WB_CYCLES_RAW < 1) ? 1 : WB_CYCLES_RAW;
	localparam logic [1:0] WB_LOAD = 2'(WB_CYCLES);
	localparam int STROBE_DIV = 2;
	// reset values
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [CNT_W-1:0] CNT_RST = 13'h0000;
	localparam logic [ROW_W-1:0] ROW_RST = 17'h00000;

	typedef enum logic [3:0] {
		OP_READ = 4'h0,
		OP_READ_NOCMD = 4'h1,
		OP_COL_READ = 4'h2,
		OP_CACHE_NEXT = 4'h3,
		OP_CACHE_LAST = 4'h4,
		OP_MREAD_SEL = 4'h5,
		OP_MREAD_GO = 4'h6,
		OP_PROG = 4'h7,
		OP_PROG_MD = 4'h8,
		OP_PROG_COL = 4'h9,
		OP_STATUS = 4'ha,
		OP_RESET = 4'hb
	} nrps_op_t;

	typedef enum logic [1:0] {
		CL_NONE = 2'h0,
		CL_GO = 2'h1,
		CL_HOLD = 2'h2,
		CL_CACHE = 2'h3
	} nrps_close_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CMD1 = 3'h1,
		ST_ADDR = 3'h3,
		ST_DATA = 3'h2,
		ST_CMD2 = 3'h6,
		ST_WB = 3'h7,
		ST_BUSY = 3'h5
	} nrps_state_t;

	typedef struct packed {
		nrps_op_t op;
		nrps_close_t close;
		logic [COL_W-1:0] col;
		logic [ROW_W-1:0] row;
		logic [CNT_W-1:0] count;
	} nrps_order_t;

	typedef struct packed {
		logic has_cmd1;
		logic [7:0] cmd1;
		logic [2:0] naddr;
		logic [2:0] addr_first;
		logic wr;
		logic rd;
		logic has_cmd2;
		logic [7:0] cmd2;
		logic wait_rb;
	} nrps_plan_t;

	typedef struct packed {
		logic fail_cur;
		logic fail_prev;
		logic pb_ready;
		logic dc_ready;
	} nrps_status_t;
endpackage : nrps_pkg

// ### src/nrps_tick.sv
// phase enable divider for the strobe timing
`timescale 1ns/10ps
module nrps_tick #(
	parameter int DIV = 2
) (
	input logic clock,
	input logic rst_n,
	output logic tick
);
	logic [7:0] cnt_ff; // cycles since last pulse
	logic tick_ff; // one-cycle enable

	// free running count, pulse once per period
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			cnt_ff <= 8'h00;
			tick_ff <= 1'b0;
		end
		else if (cnt_ff == 8'(DIV - 1))
		begin
			cnt_ff <= 8'h00;
			tick_ff <= 1'b1;
		end
		else
		begin
			cnt_ff <= cnt_ff + 8'h01;
			tick_ff <= 1'b0;
		end
	end

	assign tick = tick_ff;
endmodule : nrps_tick

// ### src/nrps_buf2.sv
// two-entry skid buffer with valid/ready on both sides
`timescale 1ns/10ps
module nrps_buf2 #(
	parameter int W = 8
) (
	input logic clock,
	input logic rst_n,
	input logic in_valid,
	input logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	input logic out_ready,
	output logic [W-1:0] out_data
);
	logic head_v_ff; // head entry holds a word
	logic spare_v_ff; // second entry holds a word
	logic [W-1:0] head_ff; // word shown at the output
	logic [W-1:0] spare_ff; // word waiting behind it
	logic push; // word taken this cycle
	logic pop; // word drained this cycle

	// ready comes from a flop, so full is honest one cycle early
	assign push = in_valid && !spare_v_ff;
	assign pop = head_v_ff && out_ready;

	// head and spare movement
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			head_v_ff <= 1'b0;
			spare_v_ff <= 1'b0;
			head_ff <= '0;
			spare_ff <= '0;
		end
		else if (pop && spare_v_ff)
		begin
			// spare moves up; push cannot occur while spare is full
			head_ff <= spare_ff;
			spare_v_ff <= 1'b0;
		end
		else if (pop)
		begin
			head_v_ff <= push;
			if (push)
			begin
				head_ff <= in_data;
			end
		end
		else if (push && head_v_ff)
		begin
			spare_ff <= in_data;
			spare_v_ff <= 1'b1;
		end
		else if (push)
		begin
			head_ff <= in_data;
			head_v_ff <= 1'b1;
		end
	end

	assign in_ready = !spare_v_ff;
	assign out_valid = head_v_ff;
	assign out_data = head_ff;
endmodule : nrps_buf2

// ### verification/nrps_host_properties.sv
// pin-level assertions for the flash host sequencer
`timescale 1ns/10ps
module nrps_chk (
	input logic clock,
	input logic rst_n,
	input nrps_pkg::nrps_order_t order,
	input logic order_valid,
	input logic order_ready,
	input logic order_refused,
	input logic chip_enable_n,
	input logic cmd_latch,
	input logic write_strobe_n,
	input logic read_strobe_n,
	input logic write_protect_n,
	input logic [7:0] byte_port_o,
	input logic byte_port_oe,
	input logic ready_busy_n
);
	import nrps_pkg::*;
	logic take; // an order is taken at this edge
	logic [16:0] sel_row_ff; // row of the last district select
	logic hold_ff; // a two-district program is half done
	assign take = order_valid && order_ready;
	// first district row, for the page match check
	always_ff @(posedge clock)
		if (!rst_n) sel_row_ff <= 17'h00000;
		else if (take && order.op == OP_MREAD_SEL) sel_row_ff <= order.row;
	// an open 80h..11h program limits what may follow
	always_ff @(posedge clock)
		if (!rst_n) hold_ff <= 1'b0;
		else if (take && (order.op == OP_PROG || order.op == OP_PROG_MD))
			hold_ff <= (order.close == CL_HOLD);
		else if (take && order.op == OP_RESET) hold_ff <= 1'b0;
	default clocking dc @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence cmd_w(logic [7:0] c);
		cmd_latch && !write_strobe_n && byte_port_o == c;
	endsequence
	sequence read_take;
		take && order.op == OP_READ ##1 !order_refused;
	endsequence
	read_seq_a: assert property (read_take |-> ##[1:20] cmd_w(CMD_READ) ##[1:90] cmd_w(CMD_READ_GO))
		else $error("read without 00h then 30h");
	wp_high_a: assert property (!chip_enable_n |-> write_protect_n)
		else $error("write protect low in order");
	wr_hold_a: assert property (!write_strobe_n && $past(!write_strobe_n) |-> $stable(byte_port_o) && byte_port_oe)
		else $error("byte moved under write strobe");
	rd_port_a: assert property (!read_strobe_n |-> !byte_port_oe && write_strobe_n && !cmd_latch)
		else $error("port driven while reading");
	busy_quiet_a: assert property (!ready_busy_n ##1 !ready_busy_n |-> read_strobe_n && write_strobe_n)
		else $error("strobe while busy");
	mread_page_a: assert property (take && order.op == OP_MREAD_GO && (order.row[5:0] != sel_row_ff[5:0] || order.row[6] == sel_row_ff[6]) |-> ##[1:2] order_refused)
		else $error("bad district pair taken");
	hold_refuse_a: assert property (take && hold_ff && !(order.op inside {OP_PROG_MD, OP_STATUS, OP_RESET}) |-> ##[1:2] order_refused)
		else $error("command taken inside 11h..81h");
	refuse_quiet_a: assert property (order_refused |-> chip_enable_n && write_strobe_n)
		else $error("refused order touched pins");
endmodule : nrps_chk
bind nrps_host nrps_chk nrps_chk_inst (.clock, .rst_n, .order, .order_valid, .order_ready,
	.order_refused, .chip_enable_n, .cmd_latch, .write_strobe_n, .read_strobe_n,
	.write_protect_n, .byte_port_o, .byte_port_oe, .ready_busy_n);

// ### verification/nrps_flash_model.sv
// behavioural flash device answering the host sequencer
`timescale 1ns/10ps
module nrps_flash_model (
	input logic chip_enable_n,
	input logic cmd_latch,
	input logic addr_latch,
	input logic write_strobe_n,
	input logic read_strobe_n,
	input logic [7:0] byte_port_o,
	input logic fail_inj,
	output logic [7:0] byte_port_i,
	output logic ready_busy_n
);
	logic [7:0] cmd = 8'h00; // powers up holding read
	logic [7:0] dout = 8'h00; // byte shown while read strobe is low
	logic [12:0] col = 13'h0000; // column counter
	logic [16:0] row = 17'h00000; // row from the address bytes
	logic [16:0] cache_row = 17'h00000; // page now in the data cache
	logic [2:0] idx = 3'h0; // next address byte position
	logic [1:0] st = 2'h0; // previous and current page failure
	logic multi = 1'b0; // second district of a multi-page program
	logic [7:0] cmd_log [$]; // commands seen, read by the bench
	logic [7:0] addr_log [$];
	logic [7:0] din_log [$];
	initial ready_busy_n = 1'b1;
	// blocking the latch process: a busy part ignores strobes anyway
	task automatic busy(input int ns);
		ready_busy_n = 1'b0;
		#(ns);
		ready_busy_n = 1'b1;
	endtask : busy
	// commands, addresses and data land on the rising write strobe
	always @(posedge write_strobe_n)
		if (!chip_enable_n && cmd_latch)
		begin
			cmd_log.push_back(byte_port_o);
			cmd = byte_port_o;
			idx = (cmd == 8'h60) ? 3'h2 : 3'h0; // select groups carry rows only
			if (cmd == 8'h30) cache_row = row;
			if (cmd == 8'h31 || cmd == 8'h3f) cache_row = cache_row + 17'h1;
			if (cmd == 8'h31 || cmd == 8'h3f) col = 13'h0000;
			if (cmd == 8'h81) multi = 1'b1;
			if (cmd == 8'h80) multi = 1'b0;
			if (cmd inside {8'h10, 8'h11, 8'h15}) st = {st[0], fail_inj | (multi & st[0])};
			if (cmd inside {8'h30, 8'h31, 8'h3f, 8'hff}) busy(600);
			if (cmd inside {8'h10, 8'h11, 8'h15}) busy(1500);
		end
		else if (!chip_enable_n && addr_latch)
		begin
			addr_log.push_back(byte_port_o);
			case (idx) // two column then three row bytes
				3'h0: col[7:0] = byte_port_o;
				3'h1: col[12:8] = byte_port_o[4:0];
				3'h2: row[7:0] = byte_port_o; // bit six picks the district
				3'h3: row[15:8] = byte_port_o;
				default: row[16] = byte_port_o[0];
			endcase
			idx = idx + 3'h1;
		end
		else if (!chip_enable_n)
			din_log.push_back(byte_port_o);
	// each falling read strobe gives the next byte
	always @(negedge read_strobe_n)
	begin
		dout = (cmd == 8'h70) ? {1'b1, {2{ready_busy_n}}, 3'h0, st} : cache_row[7:0] + col[7:0];
		col = col + 13'h1;
	end
	// a released port never repeats the last byte
	assign byte_port_i = read_strobe_n ? ~dout : dout;
endmodule : nrps_flash_model

// ### verification/tb_nrps_host.sv
// self-checking bench for the flash host sequencer
`timescale 1ns/10ps
`define FM nrps_flash_model_inst
`define CHK(a, b) \
	begin \
		n_checks++; \
		if ((a) !== (b)) \
		begin \
			fail_count++; \
			$display("unexpected at %0t: got %h want %h", $time, (a), (b)); \
		end \
	end
module tb_nrps_host;
	import nrps_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	nrps_order_t order = '0;
	logic order_valid = 1'b0;
	logic order_ready, order_done, order_refused, wr_ready, rd_valid;
	logic [7:0] wr_data = 8'h00;
	logic wr_valid = 1'b0;
	logic [7:0] rd_data;
	logic rd_ready = 1'b0;
	nrps_status_t status;
	logic protect = 1'b1;
	logic chip_enable_n, cmd_latch, addr_latch, write_strobe_n, read_strobe_n, write_protect_n;
	logic [7:0] byte_port_o, byte_port_i;
	logic byte_port_oe, ready_busy_n;
	logic fail_inj = 1'b0; // model fails the next programmed page
	logic [7:0] got [$]; // bytes handed out at the read side
	logic [39:0] a40 = 40'h001f030001; // expected five address bytes
	int unsigned cyc = 0; // free count for the stall pattern
	int fail_count = 0;
	int n_checks = 0;
	int i;
	nrps_host nrps_host_inst (.clock, .rst_n, .order, .order_valid, .order_ready, .order_done,
		.order_refused, .wr_data, .wr_valid, .wr_ready, .rd_data, .rd_valid, .rd_ready, .status,
		.protect, .chip_enable_n, .cmd_latch, .addr_latch, .write_strobe_n, .read_strobe_n,
		.write_protect_n, .byte_port_o, .byte_port_oe, .byte_port_i, .ready_busy_n);
	nrps_flash_model nrps_flash_model_inst (.chip_enable_n, .cmd_latch, .addr_latch,
		.write_strobe_n, .read_strobe_n, .byte_port_o, .fail_inj, .byte_port_i, .ready_busy_n);
	initial forever #50 clock = ~clock;
	// reader stalls two cycles in eight, so the buffer must hold bytes
	always @(negedge clock)
	begin
		cyc <= cyc + 1;
		rd_ready <= rst_n && (cyc[2:1] != 2'h0);
	end
	always @(posedge clock)
		if (rd_valid === 1'b1 && rd_ready)
			got.push_back(rd_data);
	// a fresh program byte follows each accepted one
	always @(posedge clock)
		if (wr_valid && wr_ready === 1'b1)
			wr_data <= wr_data + 8'h01;
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test
	// offer one order, wait for done or refusal
	task automatic run(input nrps_op_t op, input nrps_close_t cl, input logic [12:0] c,
		input logic [16:0] r, input logic [12:0] n, input logic exp_rf);
		int k;
		order = '{op, cl, c, r, n};
		order_valid = 1'b1;
		for (k = 0; order_ready !== 1'b1 && k < 100; k++) @(negedge clock);
		@(negedge clock);
		order_valid = 1'b0;
		for (k = 0; order_done !== 1'b1 && order_refused !== 1'b1 && k < 500; k++) @(negedge clock);
		`CHK(order_done | order_refused, 1'b1) // a hung order counts
		`CHK(order_refused, exp_rf)
		@(negedge clock);
		$display("order %s ended", op.name());
	endtask : run
	task automatic rdchk(input logic [7:0] base, input int n);
		int k;
		logic [7:0] b;
		for (k = 0; got.size() < n && k < 100; k++) @(negedge clock);
		for (k = 0; k < n; k++)
		begin
			b = got.pop_front();
			`CHK(b, base + 8'(k))
		end
	endtask : rdchk
	task automatic ck_cmd(input logic [23:0] e, input int n);
		logic [7:0] b;
		`CHK(`FM.cmd_log.size(), n)
		for (int k = n - 1; k >= 0; k--)
		begin
			b = `FM.cmd_log.pop_front();
			`CHK(b, e[k*8 +: 8])
		end
	endtask : ck_cmd
	initial
	begin
		#2000000;
		fail_count++;
		finish_test();
	end
	initial
	begin
		repeat (2) @(negedge clock);
		rst_n = 1'b1;
		wr_valid = 1'b1;
		@(negedge clock);
		run(OP_READ_NOCMD, CL_NONE, 13'h0010, 17'h00041, 13'h4, 1'b0);
		ck_cmd(24'h000030, 1);
		rdchk(8'h51, 4);
		`FM.addr_log.delete();
		run(OP_READ, CL_NONE, 13'h1f00, 17'h10003, 13'h3, 1'b0);
		ck_cmd(24'h000030, 2);
		for (i = 0; i < 5; i++) `CHK(`FM.addr_log[i], a40[39-8*i -: 8])
		rdchk(8'h03, 3);
		run(OP_COL_READ, CL_NONE, 13'h0020, 17'h10003, 13'h2, 1'b0);
		ck_cmd(24'h0005e0, 2);
		rdchk(8'h23, 2);
		run(OP_CACHE_NEXT, CL_NONE, 13'h0, 17'h0, 13'h2, 1'b0);
		rdchk(8'h04, 2);
		run(OP_CACHE_LAST, CL_NONE, 13'h0, 17'h0, 13'h1, 1'b0);
		rdchk(8'h05, 1);
		ck_cmd(24'h00313f, 2);
		run(OP_READ, CL_NONE, 13'h0, 17'h0007f, 13'h1, 1'b0);
		rdchk(8'h7f, 1);
		run(OP_CACHE_NEXT, CL_NONE, 13'h0, 17'h0, 13'h1, 1'b1);
		ck_cmd(24'h000030, 2);
		run(OP_MREAD_SEL, CL_NONE, 13'h0, 17'h00005, 13'h0, 1'b0);
		run(OP_MREAD_GO, CL_NONE, 13'h0, 17'h00045, 13'h2, 1'b0);
		ck_cmd(24'h606030, 3);
		rdchk(8'h46, 2);
		run(OP_MREAD_GO, CL_NONE, 13'h0, 17'h00046, 13'h1, 1'b1);
		run(OP_MREAD_GO, CL_NONE, 13'h0, 17'h000c5, 13'h1, 1'b1);
		`FM.din_log.delete();
		run(OP_PROG, CL_NONE, 13'h0, 17'h00080, 13'h2, 1'b0);
		run(OP_PROG_COL, CL_GO, 13'h0040, 17'h0, 13'h2, 1'b0);
		ck_cmd(24'h808510, 3);
		`CHK(8'(`FM.din_log[3] - `FM.din_log[0]), 8'h03)
		fail_inj = 1'b1;
		run(OP_PROG, CL_HOLD, 13'h0, 17'h0, 13'h1, 1'b0);
		run(OP_READ, CL_NONE, 13'h0, 17'h0, 13'h1, 1'b1);
		run(OP_STATUS, CL_NONE, 13'h0, 17'h0, 13'h1, 1'b0);
		`CHK(status, 4'hb)
		fail_inj = 1'b0;
		run(OP_PROG_MD, CL_GO, 13'h0, 17'h00040, 13'h1, 1'b0);
		run(OP_STATUS, CL_NONE, 13'h0, 17'h0, 13'h1, 1'b0);
		`CHK(status, 4'hf)
		fail_inj = 1'b1;
		run(OP_PROG, CL_CACHE, 13'h0, 17'h00002, 13'h1, 1'b0);
		fail_inj = 1'b0;
		run(OP_PROG, CL_GO, 13'h0, 17'h00003, 13'h1, 1'b0);
		run(OP_STATUS, CL_NONE, 13'h0, 17'h0, 13'h1, 1'b0);
		`CHK(status, 4'h7)
		`FM.cmd_log.delete();
		run(OP_RESET, CL_NONE, 13'h0, 17'h0, 13'h0, 1'b0);
		ck_cmd(24'h0000ff, 1);
		`CHK(write_protect_n, 1'b0)
		finish_test();
	end
endmodule : tb_nrps_host
